// File: src/lcc_cell.sv
// logic cell: four-input lut, carry and one register with clear and preset
`timescale 1ns/1ps
module lcc_cell
  import lcc_pkg::*;
#(
  parameter bit POWERUP = 1'b0
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  // configuration
  input wire logic [MASK_W-1:0] i_mask,
  input wire logic [1:0] i_clk_sel,
  input wire lcc_clr_sel_type i_clr_sel,
  input wire logic i_pre_en,
  input wire logic i_lut_chain,
  input wire logic i_reg_chain,
  input wire logic i_arith,
  // data and chains
  input wire logic [LUT_IN-1:0] i_lut_in,
  input wire logic i_lut_prev,
  input wire logic i_q_prev,
  input wire logic i_carry,
  // cluster-wide controls
  input wire logic [NUM_GLOBAL-1:0] i_gclk_rise,
  input wire logic i_clr_a,
  input wire logic i_clr_b,
  input wire logic i_preset,
  input wire logic i_chip_rst,
  // results
  output logic o_lut,
  output logic o_q,
  output logic o_carry
);
  logic a;
  logic d;
  logic clr;
  logic [LUT_IN-1:0] idx;

  // ----------------------------------------
  // lut and carry
  // ----------------------------------------
  always_comb begin
    a = i_lut_chain ? i_lut_prev : i_lut_in[0];
    idx = {i_lut_in[LUT_IN-1:1], a};
    o_lut = i_arith ? (a ^ i_lut_in[1] ^ i_carry) : i_mask[idx];
  end

  assign o_carry = i_arith & ((a & i_lut_in[1]) | (i_carry & (a | i_lut_in[1])));
  assign d = i_reg_chain ? i_q_prev : o_lut;
  assign clr = ((i_clr_sel == CLR_A) & i_clr_a) | ((i_clr_sel == CLR_B) & i_clr_b);

  // ----------------------------------------
  // register
  // ----------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_q <= POWERUP;
    end else if (i_ce) begin
      if (i_chip_rst) o_q <= 1'b0;
      else if (clr) o_q <= 1'b0;
      else if (i_preset && i_pre_en) o_q <= 1'b1;
      else if (i_gclk_rise[i_clk_sel]) o_q <= d;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  AST_CLR_PRIO: assert property (i_ce && !i_chip_rst && clr && i_preset && i_pre_en |=> !o_q)
    else $error("clear lost to preset");
  AST_CHIP_RST: assert property (i_ce && i_chip_rst |=> !o_q)
    else $error("chip reset did not clear register");
  AST_PRESET: assert property (i_ce && !i_chip_rst && !clr && i_preset && i_pre_en |=> o_q)
    else $error("preset did not load one");
  AST_CAPTURE: assert property (i_ce && !i_chip_rst && !clr && !(i_preset && i_pre_en)
      && i_gclk_rise[i_clk_sel] |=> o_q == $past(d))
    else $error("register missed its clock edge");
endmodule // lcc_cell

// File: src/lcc_cfg_mem.sv
// configuration memory: word array with registered read port
`timescale 1ns/1ps
module lcc_cfg_mem
  import lcc_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  // access port
  input wire logic i_we,
  input wire logic [CFG_AW-1:0] i_addr,
  input wire logic [WORD_W-1:0] i_wdata,
  output logic [WORD_W-1:0] o_rdata,
  // whole contents for the cells
  output logic [CFG_WORDS*WORD_W-1:0] o_words
);
  logic [WORD_W-1:0] mem_q [CFG_WORDS];

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      for (int k = 0; k < CFG_WORDS; k++) mem_q[k] <= '0;
    end else if (i_ce && i_we && (i_addr < CFG_AW'(CFG_WORDS))) begin
      mem_q[i_addr] <= i_wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_rdata <= '0;
    end else if (i_ce) begin
      o_rdata <= (i_addr < CFG_AW'(CFG_WORDS)) ? mem_q[i_addr] : '0;
    end
  end

  always_comb begin
    for (int k = 0; k < CFG_WORDS; k++) o_words[k*WORD_W +: WORD_W] = mem_q[k];
  end
endmodule // lcc_cfg_mem

// File: src/lcc_cluster.sv
// logic cluster: ten cells, local routing, cluster controls and apb access
//
// The register offsets and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
module lcc_cluster
  import lcc_pkg::*;
#(
  parameter bit CHIP_RST_EN = 1'b1,
  parameter logic [NUM_CELLS-1:0] POWERUP_VAL = '0
) (
  // clock, reset, enable
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [WORD_W-1:0] i_pwdata,
  output logic [WORD_W-1:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // global lines and routing
  input wire logic [NUM_GLOBAL-1:0] i_global,
  input wire logic [NUM_ROWCOL-1:0] i_row_column_routing,
  input wire logic [NUM_LINK-1:0] i_neighbour_link_left,
  input wire logic [NUM_LINK-1:0] i_neighbour_link_right,
  output logic [NUM_CELLS-1:0] o_cell_out,
  // carry chain along the row
  input wire logic i_carry_in,
  output logic o_carry_out,
  // chip reset pin
  input wire logic i_chip_reset_n,
  output logic o_chip_pin_out,
  output logic o_chip_pin_oe_n
);

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  lcc_apb_state_type state_q;
  lcc_apb_state_type state_d;
  logic [CTRL_W-1:0] ctrl_q;
  logic [IOCTL_W-1:0] ioctl_q;
  logic [WORD_W-1:0] prdata_q;
  logic [WORD_W-1:0] rd_mux;
  logic [WORD_W-1:0] cfg_rdata;
  logic [WORD_W-1:0] status_w;
  logic [CFG_WORDS*WORD_W-1:0] cfg_words;
  logic in_cfg;
  logic addr_ok;
  logic wr_en;
  logic [NUM_GLOBAL-1:0] gl_q;
  logic [NUM_GLOBAL-1:0] gl_rise;
  logic clr_a;
  logic clr_b;
  logic preset;
  logic chip_rst;
  logic [POOL_W-1:0] pool;
  logic [NUM_CELLS-1:0] cell_q;
  logic [NUM_CELLS-1:0] lut_o;
  logic [NUM_CELLS-1:0] lut_prev;
  logic [NUM_CELLS-1:0] q_prev;
  logic [NUM_CELLS:0] carry;
  logic [NUM_CELLS-1:0] clra_use;
  logic [NUM_CELLS-1:0] clrb_use;
  logic [NUM_CELLS-1:0] pre_use;
  logic pin_out_q;

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  assign in_cfg = (i_paddr < A_CFG_END);

  always_comb begin
    addr_ok = (i_paddr[ADDR_LSB-1:0] == '0)
      && (in_cfg || (i_paddr == A_CTRL) || (i_paddr == A_IOCTL) || (i_paddr == A_STATUS));
  end

  // a frozen block holds the answer back, so no write is acknowledged and lost
  assign o_pready = (state_q == ST_ACK) && i_ce;
  assign o_pslverr = o_pready && !addr_ok;
  assign wr_en = i_psel && i_penable && o_pready && i_pwrite && addr_ok;
  assign o_prdata = prdata_q;

  // ----------------------------------------
  // apb phase machine: one wait cycle per transfer
  // ----------------------------------------
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        if (i_psel && !i_penable) state_d = ST_WAIT;
      end
      ST_WAIT: begin
        state_d = ST_ACK;
      end
      ST_ACK: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      state_q <= ST_IDLE;
    end else if (i_ce) begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------
  // read data
  // ----------------------------------------
  // pin level, global lines and register values
  assign status_w = WORD_W'({i_chip_reset_n, i_global, cell_q});

  always_comb begin
    rd_mux = '0;
    if (!addr_ok) rd_mux = '0;
    else if (in_cfg) rd_mux = cfg_rdata;
    else if (i_paddr == A_CTRL) rd_mux = WORD_W'(ctrl_q);
    else if (i_paddr == A_IOCTL) rd_mux = WORD_W'(ioctl_q);
    else rd_mux = status_w;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      prdata_q <= '0;
    end else if (i_ce && state_q == ST_WAIT) begin
      prdata_q <= i_pwrite ? '0 : rd_mux;
    end
  end

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      ctrl_q <= CTRL_RST;
    end else if (i_ce && wr_en && i_paddr == A_CTRL) begin
      ctrl_q <= i_pwdata[CTRL_W-1:0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      ioctl_q <= IOCTL_RST;
    end else if (i_ce && wr_en && i_paddr == A_IOCTL) begin
      ioctl_q <= i_pwdata[IOCTL_W-1:0];
    end
  end

  lcc_cfg_mem u_cfg_mem (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_ce(i_ce),
    .i_we(wr_en && in_cfg),
    .i_addr(i_paddr[ADDR_LSB +: CFG_AW]),
    .i_wdata(i_pwdata),
    .o_rdata(cfg_rdata),
    .o_words(cfg_words)
  );

  // ----------------------------------------
  // global lines and cluster-wide controls
  // ----------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      gl_q <= '0;
    end else if (i_ce) begin
      gl_q <= i_global;
    end
  end

  assign gl_rise = i_global & ~gl_q;
  // two clears and one preset, each fed from a global line
  assign clr_a = ctl_decode(ctrl_q[F_CLRA +: CTL_W], i_global);
  assign clr_b = ctl_decode(ctrl_q[F_CLRB +: CTL_W], i_global);
  assign preset = ctl_decode(ctrl_q[F_PSRC +: CTL_W], i_global);
  // dedicated path, not one of the global lines
  assign chip_rst = CHIP_RST_EN && !i_chip_reset_n;

  // ----------------------------------------
  // local routing pool
  // ----------------------------------------
  // 0..5 row/column, 6..15 left link, 16..25 right link, 26..35 own cells
  assign pool = {cell_q, i_neighbour_link_right, i_neighbour_link_left,
                 i_row_column_routing};

  assign lut_prev = {lut_o[NUM_CELLS-2:0], 1'b0};
  assign q_prev = {cell_q[NUM_CELLS-2:0], 1'b0};
  assign carry[0] = i_carry_in && ctrl_q[F_CYEN];
  assign o_carry_out = carry[NUM_CELLS];
  // same value goes to both neighbours' links
  assign o_cell_out = cell_q;

  // ----------------------------------------
  // logic cells
  // ----------------------------------------
  for (genvar c = 0; c < NUM_CELLS; c++) begin : g_cell
    logic [WORD_W-1:0] w0;
    logic [WORD_W-1:0] w1;
    logic [LUT_IN-1:0] lin;
    assign w0 = cfg_words[(2*c)*WORD_W +: WORD_W];
    assign w1 = cfg_words[(2*c+1)*WORD_W +: WORD_W];
    assign clra_use[c] = (lcc_clr_sel_type'(w0[F_CLR +: 2]) == CLR_A);
    assign clrb_use[c] = (lcc_clr_sel_type'(w0[F_CLR +: 2]) == CLR_B);
    assign pre_use[c] = w0[F_PRE];

    for (genvar j = 0; j < LUT_IN; j++) begin : g_in
      logic [SEL_W-1:0] s;
      assign s = w1[j*SEL_W +: SEL_W];
      assign lin[j] = (s < SEL_W'(POOL_W)) ? pool[s] : 1'b0;
    end

    lcc_cell #(
      .POWERUP(POWERUP_VAL[c])
    ) u_cell (
      .i_clk(i_clk),
      .i_rstn(i_rstn),
      .i_ce(i_ce),
      .i_mask(w0[MASK_W-1:0]),
      .i_clk_sel(w0[F_CLK +: 2]),
      .i_clr_sel(lcc_clr_sel_type'(w0[F_CLR +: 2])),
      .i_pre_en(w0[F_PRE]),
      .i_lut_chain(w0[F_LCH]),
      .i_reg_chain(w0[F_RCH]),
      .i_arith(w0[F_ARI]),
      .i_lut_in(lin),
      .i_lut_prev(lut_prev[c]),
      .i_q_prev(q_prev[c]),
      .i_carry(carry[c]),
      .i_gclk_rise(gl_rise),
      .i_clr_a(clr_a),
      .i_clr_b(clr_b),
      .i_preset(preset),
      .i_chip_rst(chip_rst),
      .o_lut(lut_o[c]),
      .o_q(cell_q[c]),
      .o_carry(carry[c+1])
    );
  end

  // ----------------------------------------
  // chip reset pin as user pin
  // ----------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      pin_out_q <= 1'b0;
    end else if (i_ce) begin
      if (ioctl_q[IO_SRC_W-1:0] < IO_SRC_W'(NUM_CELLS))
        pin_out_q <= cell_q[ioctl_q[IO_SRC_W-1:0]];
      else
        pin_out_q <= 1'b0;
    end
  end

  assign o_chip_pin_out = pin_out_q;
  assign o_chip_pin_oe_n = CHIP_RST_EN || !ioctl_q[F_IOOE];

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  AST_CHIP_ALL: assert property (i_ce && chip_rst |=> cell_q == '0)
    else $error("chip reset left a register set");
  AST_PIN_USER: assert property (CHIP_RST_EN |-> o_chip_pin_oe_n)
    else $error("reset pin driven while reset is selected");
  AST_CLR_SHARED: assert property (i_ce && clr_a && !chip_rst
      |=> (cell_q & $past(clra_use)) == '0)
    else $error("shared clear missed a cell");
  AST_CLR_SECOND: assert property (i_ce && clr_b && !chip_rst
      |=> (cell_q & $past(clrb_use)) == '0)
    else $error("second clear missed a cell");
  AST_PRESET_ALL: assert property (i_ce && preset && !clr_a && !clr_b && !chip_rst
      |=> (cell_q & $past(pre_use)) == $past(pre_use))
    else $error("shared preset missed a cell");
  AST_POWERUP: assert property (disable iff (1'b0) !i_rstn |=> cell_q == POWERUP_VAL)
    else $error("wrong power-up value");
  AST_LUT_CHAIN: assert property (g_cell[1].w0[F_LCH] && !g_cell[1].w0[F_ARI]
      |-> lut_o[1] == g_cell[1].w0[{g_cell[1].lin[LUT_IN-1:1], lut_o[0]}])
    else $error("lut chain not taken");
  AST_CELL0_CLK: assert property (i_ce && !chip_rst && !clr_a && !clr_b && !preset
      && gl_rise[g_cell[0].w0[F_CLK +: 2]] && !g_cell[0].w0[F_RCH]
      |=> cell_q[0] == $past(lut_o[0]))
    else $error("cell 0 missed its global clock");
  AST_HOLD: assert property (i_ce && !chip_rst && !clr_a && !clr_b && !preset
      && gl_rise == '0 |=> cell_q == $past(cell_q))
    else $error("register changed with no cause");
  AST_CE_FREEZE: assert property (!i_ce
      |=> cell_q == $past(cell_q) && state_q == $past(state_q))
    else $error("state moved while frozen");
  AST_PIN_SRC: assert property (i_ce && ioctl_q[IO_SRC_W-1:0] < IO_SRC_W'(NUM_CELLS)
      |=> o_chip_pin_out == $past(cell_q[ioctl_q[IO_SRC_W-1:0]]))
    else $error("user pin lost its source cell");
  AST_ROW_CARRY: assert property (!ctrl_q[F_CYEN] |-> !carry[0])
    else $error("carry entered from outside the row");

  // ----------------------------------------
  // checks: register bus
  // ----------------------------------------
  AST_APB_WAIT: assert property (state_q == ST_IDLE && i_ce && i_psel && !i_penable
      |=> !o_pready ##1 o_pready)
    else $error("apb answer timing broken");
  AST_WR_CTRL: assert property (wr_en && i_paddr == A_CTRL
      |=> ctrl_q == $past(i_pwdata[CTRL_W-1:0]))
    else $error("control write lost");
  AST_WR_IOCTL: assert property (wr_en && i_paddr == A_IOCTL
      |=> ioctl_q == $past(i_pwdata[IOCTL_W-1:0]))
    else $error("pin control write lost");
  AST_ERR_NOWR: assert property (o_pslverr
      |=> ctrl_q == $past(ctrl_q) && ioctl_q == $past(ioctl_q))
    else $error("refused transfer changed a register");
  AST_ERR_DATA: assert property (o_pslverr |-> o_prdata == '0)
    else $error("refused transfer returned data");
  AST_RD_STATUS: assert property (i_ce && state_q == ST_WAIT && !i_pwrite
      && i_paddr == A_STATUS |=> o_prdata == $past(status_w))
    else $error("status read returned stale data");

endmodule // lcc_cluster

// File: src/lcc_pkg.sv
// package: constants, types and helpers for the logic cluster
package lcc_pkg;

  // ----------------------------------------
  // structure
  // ----------------------------------------
  localparam int unsigned NUM_CELLS = 10;
  localparam int unsigned NUM_GLOBAL = 4;
  localparam int unsigned NUM_ROWCOL = 6;
  localparam int unsigned NUM_LINK = 10;
  localparam int unsigned POOL_W = 36;
  localparam int unsigned SEL_W = 6;
  localparam int unsigned LUT_IN = 4;
  localparam int unsigned MASK_W = 16;
  localparam int unsigned WORD_W = 32;
  localparam int unsigned CFG_WORDS = 20;
  localparam int unsigned CFG_AW = 5;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned ADDR_LSB = 2;

  // ----------------------------------------
  // register map (byte addresses)
  // ----------------------------------------
  localparam logic [ADDR_W-1:0] A_CFG_END = 8'h50;
  localparam logic [ADDR_W-1:0] A_CTRL = 8'h80;
  localparam logic [ADDR_W-1:0] A_IOCTL = 8'h84;
  localparam logic [ADDR_W-1:0] A_STATUS = 8'h88;

  // cell word 0: lut mask in [15:0], mode fields above
  localparam int unsigned F_CLK = 16;
  localparam int unsigned F_CLR = 18;
  localparam int unsigned F_PRE = 20;
  localparam int unsigned F_LCH = 21;
  localparam int unsigned F_RCH = 22;
  localparam int unsigned F_ARI = 23;

  // control word: three 3-bit sources, then carry-in enable
  localparam int unsigned CTL_W = 3;
  localparam int unsigned F_CLRA = 0;
  localparam int unsigned F_CLRB = 3;
  localparam int unsigned F_PSRC = 6;
  localparam int unsigned F_CYEN = 9;
  localparam int unsigned CTRL_W = 10;
  localparam logic [CTRL_W-1:0] CTRL_RST = 10'h000;

  // io control word: pin source cell, pin drive enable
  localparam int unsigned IO_SRC_W = 4;
  localparam int unsigned F_IOOE = 4;
  localparam int unsigned IOCTL_W = 5;
  localparam logic [IOCTL_W-1:0] IOCTL_RST = 5'h00;

  // ----------------------------------------
  // types and helpers
  // ----------------------------------------
  typedef enum logic [1:0] {
    CLR_NONE = 2'b00,
    CLR_A = 2'b01,
    CLR_B = 2'b10
  } lcc_clr_sel_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_ACK = 2'b10
  } lcc_apb_state_type;

  // control source: bit 2 enables, bits 1:0 pick a global line
  function automatic logic ctl_decode(input logic [CTL_W-1:0] f,
                                      input logic [NUM_GLOBAL-1:0] g);
    return f[CTL_W-1] & g[f[1:0]];
  endfunction

endpackage

// File: testbench/lcc_fabric_model.sv
// model of the neighbour clusters, the routing fabric and the board reset logic
`timescale 1ns/1ps
module lcc_fabric_model
  import lcc_pkg::*;
(
  // clock
  input wire logic i_clk,
  // values requested by the bench
  input wire logic [NUM_ROWCOL-1:0] i_rc,
  input wire logic [NUM_LINK-1:0] i_left,
  input wire logic [NUM_LINK-1:0] i_right,
  input wire logic i_carry,
  input wire logic i_hold_rst,
  // toward the cluster
  output logic [NUM_ROWCOL-1:0] o_rc,
  output logic [NUM_LINK-1:0] o_left,
  output logic [NUM_LINK-1:0] o_right,
  output logic o_carry,
  output logic o_chip_reset_n
);
  // ----------------------------------------
  // neighbours launch from their own registers
  // ----------------------------------------
  always_ff @(posedge i_clk) begin
    o_rc <= i_rc;
    o_left <= i_left;
    o_right <= i_right;
    o_carry <= i_carry;
  end
  // ----------------------------------------
  // board logic holds the chip reset low on request
  // ----------------------------------------
  always_ff @(posedge i_clk) begin
    o_chip_reset_n <= ~i_hold_rst;
  end
endmodule // lcc_fabric_model

// File: testbench/logic_cluster_register_control_test.sv
// self-checking bench for the logic cluster
`timescale 1ns/1ps
`define CHK(nm, got, exp) begin checks_done++; if ((got) !== (exp)) begin miscompares++; \
  $display("mismatch %s expected %h seen %h", nm, exp, got); end end
module logic_cluster_register_control_test
  import lcc_pkg::*;
;
  localparam logic [NUM_CELLS-1:0] PWR = 10'h205;
  logic i_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [WORD_W-1:0] pwdata = '0;
  logic [WORD_W-1:0] prdata;
  logic pready, pslverr, carry_out, pin_out, pin_oe_n, carry_in, chip_reset_n;
  logic [NUM_GLOBAL-1:0] glob = '0;
  logic [NUM_ROWCOL-1:0] rc_d = 6'h01;
  logic [NUM_ROWCOL-1:0] rc;
  logic [NUM_LINK-1:0] left_d = '0;
  logic [NUM_LINK-1:0] right_d = '0;
  logic [NUM_LINK-1:0] left, right;
  logic [NUM_CELLS-1:0] cells;
  logic carry_d = 1'b0;
  logic hold_rst = 1'b0;
  logic ce = 1'b1;
  logic [WORD_W:0] notes[$];
  logic [WORD_W:0] note;
  logic [31:0] rnd = 32'h5aa50fe8;
  logic [31:0] cfg[4] = '{32'h0000aaaa, 32'h0040aaaa, 32'h0014aaaa, 32'h0018aaaa};
  int miscompares = 0;
  int checks_done = 0;
  int cycles = 0;

  always #5 i_clk = ~i_clk;

  lcc_cluster #(.CHIP_RST_EN(1'b1), .POWERUP_VAL(PWR)) dut_u (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_ce(ce),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_global(glob), .i_row_column_routing(rc), .i_neighbour_link_left(left),
    .i_neighbour_link_right(right), .o_cell_out(cells), .i_carry_in(carry_in),
    .o_carry_out(carry_out), .i_chip_reset_n(chip_reset_n), .o_chip_pin_out(pin_out),
    .o_chip_pin_oe_n(pin_oe_n));

  lcc_fabric_model fab_u (
    .i_clk(i_clk), .i_rc(rc_d), .i_left(left_d), .i_right(right_d), .i_carry(carry_d),
    .i_hold_rst(hold_rst), .o_rc(rc), .o_left(left), .o_right(right), .o_carry(carry_in),
    .o_chip_reset_n(chip_reset_n));

  // ----------------------------------------
  // monitor, timeout and closing
  // ----------------------------------------
  // read data is taken at the edge that samples pready high
  always @(posedge i_clk) begin
    if (psel && penable && !pwrite && pready === 1'b1) begin
      note = notes.pop_front();
      `CHK("read response", {pslverr, prdata}, note)
    end
  end

  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      test_done();
    end
  end

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------
  // drivers
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask

  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] d,
                     input logic [WORD_W:0] exp);
    @(posedge i_clk);
    if (!w) begin
      notes.push_back(exp);
    end
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    penable <= 1'b1;
    @(posedge i_clk);
    while (pready !== 1'b1) @(posedge i_clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] d);
    apb(1'b1, a, d, '0);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [WORD_W:0] exp);
    apb(1'b0, a, '0, exp);
  endtask

  // status read: pin level, global lines and cell registers
  task automatic st(input logic [NUM_CELLS-1:0] c);
    tick(2);
    rd(A_STATUS, {18'h0, chip_reset_n, glob, c});
  endtask

  task automatic gl(input int k, input logic v);
    @(posedge i_clk);
    glob[k] <= v;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    tick(5);
    i_rstn <= 1'b1;
    st(PWR);
    `CHK("cell outputs", cells, PWR)
    `CHK("pin drive enable", pin_oe_n, 1'b1)
    wr(8'h4c, 32'h00000fc0);
    rd(8'h4c, {1'b0, 32'h00000fc0});
    rd(A_CFG_END, {1'b1, 32'h0});
    // every cell adds with a zero operand, so the carry ripples through all ten
    for (int i = 0; i < 10; i++) begin
      wr(8'(8 * i), 32'h00800000);
      wr(8'(8 * i + 4), 32'h00000fc0);
    end
    for (int n = 0; n < 8; n++) begin
      rnd = lfsr(rnd);
      wr(A_CTRL, {22'h0, rnd[3], 9'h0});
      rc_d <= rnd[9:4] | 6'h01;
      left_d <= rnd[19:10];
      right_d <= rnd[29:20];
      carry_d <= rnd[30];
      tick(2);
      @(negedge i_clk);
      `CHK("carry out", carry_out, rnd[30] & rnd[3])
    end
    // cell roles: 0 plain, 1 register chain, 2 clear a and preset, 3 clear b and preset, rest plain
    for (int i = 0; i < 10; i++) begin
      wr(8'(8 * i), (i < 4) ? cfg[i] : cfg[0]);
      wr(8'(8 * i + 4), 32'h0);
    end
    wr(A_CTRL, 32'h000001bd);
    rc_d <= 6'h01;
    tick(2);
    gl(0, 1'b1);
    st(10'h3ff);
    gl(0, 1'b0);
    rc_d <= 6'h00;
    tick(2);
    gl(0, 1'b1);
    st(10'h002);
    gl(2, 1'b1);
    st(10'h00e);
    gl(1, 1'b1);
    st(10'h00a);
    gl(3, 1'b1);
    st(10'h002);
    gl(1, 1'b0);
    gl(3, 1'b0);
    st(10'h00e);
    // chip reset against a clock edge and an active preset
    gl(0, 1'b0);
    rc_d <= 6'h01;
    hold_rst <= 1'b1;
    gl(0, 1'b1);
    st(10'h000);
    `CHK("cell outputs", cells, 10'h000)
    hold_rst <= 1'b0;
    st(10'h00c);
    // reset pin stays an input while its reset job is selected; cell 3 feeds the user pin
    wr(A_IOCTL, 32'h00000013);
    rd(A_IOCTL, {1'b0, 32'h00000013});
    `CHK("pin out", pin_out, 1'b1)
    `CHK("pin drive enable", pin_oe_n, 1'b1)
    // clear a arrives while the block is frozen, and acts once it runs again
    ce <= 1'b0;
    gl(1, 1'b1);
    tick(3);
    `CHK("frozen cells", cells, 10'h00c)
    ce <= 1'b1;
    tick(2);
    `CHK("cell outputs", cells, 10'h008)
    // cell 1 inverts cell 0's lut output through the lut chain, its own input 0 reads 0
    wr(8'h08, 32'h00205555);
    wr(8'h0c, 32'h0000003f);
    gl(0, 1'b0);
    gl(0, 1'b1);
    st(10'h3f9);
    test_done();
  end
endmodule // logic_cluster_register_control_test
